// ---- rtl/pcc_cal_timer.sv ----
// module: calibration wait timer selected by wait code and routine
`timescale 1ns/10ps
module pcc_cal_timer
  import pcc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // control
  input wire logic go,
  input wire logic [1:0] wait_code,
  input wire logic fast,
  // status
  output logic expired
);
  logic [17:0] count;
  logic [17:0] span;
  always_comb
  begin
    unique case (wait_code)
      2'b00: span = 18'(CAL_CYC_0);
      2'b01: span = 18'(CAL_CYC_1);
      2'b10: span = 18'(CAL_CYC_2);
      2'b11: span = 18'(CAL_CYC_3);
    endcase
    if (!fast)
      span = 18'(span * NORMAL_FACTOR);
  end
  always_ff @(posedge mclk)
  begin
    if (rst || go)
      count <= '0;
    else if (!expired)
      count <= count + 18'h0_0001;
  end
  always_ff @(posedge mclk)
  begin
    if (rst || go)
      expired <= 1'b0;
    else
      expired <= (count + 18'h0_0002 >= span);
  end
endmodule // pcc_cal_timer

// ---- rtl/pcc_device.sv ----
// module: device end, calibration sequencer and lock indication
`timescale 1ns/10ps
module pcc_device
  import pcc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // link
  pcc_link_if.dev link,
  // synthesizer side
  output logic [1:0] band_divider,
  output logic [7:0] applied_bandwidth,
  output logic [2:0] vctrl_nominal
);
  typedef enum logic [1:0] {ST_IDLE, ST_CAL_A, ST_CAL_B} pcc_state_t;
  pcc_state_t state;
  logic start_d;
  logic go;
  logic expired;
  logic dual_q;
  logic [3:0] pump_a;
  logic [3:0] pump_b;
  logic [7:0] lock_cnt;
  logic done;
  logic locked;
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk)
  begin
    if (rst)
      start_d <= 1'b0;
    else
      start_d <= link.cal_start;
  end
  assign go = link.cal_start && !start_d && state == ST_IDLE;
  pcc_cal_timer timer (
    .mclk(mclk),
    .rst(rst),
    .go(go || (state == ST_CAL_A && expired && dual_q)),
    .wait_code(link.cal_wait),
    .fast(link.cal_fast),
    .expired(expired)
  );
  always_ff @(posedge mclk)
  begin
    if (rst)
      state <= ST_IDLE;
    else
      unique case (state)
        ST_IDLE: if (go) state <= (link.cal_dual || !link.word_select) ? ST_CAL_A : ST_CAL_B;
        ST_CAL_A: if (expired) state <= dual_q ? ST_CAL_B : ST_IDLE;
        ST_CAL_B: if (expired) state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
      dual_q <= 1'b0;
    else if (go)
    begin
      dual_q <= link.cal_dual;
    end
  end
  // dual always runs A then B, so dual start forces A first
  always_ff @(posedge mclk)
  begin
    if (rst)
      vctrl_nominal <= 3'h0;
    else if (go)
      vctrl_nominal <= link.calib_vctrl_code;
  end
  // results persist across later runs; only reset clears them
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pump_a <= PUMP_RESET;
      pump_b <= PUMP_RESET;
    end
    else if (expired && state == ST_CAL_A)
      pump_a <= 4'({1'b0, vctrl_nominal} + {2'b00, link.cal_wait});
    else if (expired && state == ST_CAL_B)
      pump_b <= 4'({1'b0, vctrl_nominal} + {2'b00, link.cal_wait});
  end
  always_ff @(posedge mclk)
  begin
    if (rst || go)
      done <= 1'b0;
    else if (expired && (state == ST_CAL_B || (state == ST_CAL_A && !dual_q)))
      done <= 1'b1;
  end
  // lock settles a fixed time after calibration completes
  always_ff @(posedge mclk)
  begin
    if (rst || state != ST_IDLE || !done)
      lock_cnt <= '0;
    else if (lock_cnt != 8'(LOCK_DELAY))
      lock_cnt <= lock_cnt + 8'h01;
  end
  assign locked = lock_cnt == 8'(LOCK_DELAY);
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      link.cal_done <= 1'b0;
      link.pll_locked_flag <= 1'b0;
      link.pump_current_code <= PUMP_RESET;
      link.lock_pin <= 1'b0;
    end
    else
    begin
      link.cal_done <= done;
      link.pll_locked_flag <= locked;
      link.pump_current_code <= link.word_select ? pump_b : pump_a;
      unique case (link.lock_select)
        LOCK_SEL_DONE: link.lock_pin <= done;
        LOCK_SEL_LOCK: link.lock_pin <= locked;
        default: link.lock_pin <= 1'b0;
      endcase
    end
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      band_divider <= 2'd2;
      applied_bandwidth <= BW_RESET;
    end
    else
    begin
      band_divider <= link.band_choice ? 2'd0 : 2'd2;
      if (done)
        applied_bandwidth <= link.loop_bandwidth_setting;
    end
  end
endmodule // pcc_device

// ---- rtl/pcc_host.sv ----
// module: host end, AXI4-Lite registers driving the configuration link
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/10ps
module pcc_host
  import pcc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // axi write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // link
  pcc_link_if.host link
);
  logic [31:0] ctrl;
  logic [31:0] cfg;
  logic [7:0] aw_addr;
  logic aw_have;
  logic w_have;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [2:0] lock_sync;
  logic [31:0] stat;
  ////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_have && w_have)
      begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_have && !s_axi_bvalid;
  assign s_axi_wready = !w_have && !s_axi_bvalid;
  // start is a level the device edge-detects; software clears it to rearm
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ctrl <= 32'h0000_0000;
      cfg <= {20'h0_0000, LOCK_SEL_RESET, BW_RESET};
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      if (aw_have && w_have)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == OFS_CTRL || aw_addr == OFS_CFG) ? RESP_OKAY : RESP_SLVERR;
        for (int i = 0; i < 4; i++)
        begin
          if (w_strb[i] && aw_addr == OFS_CTRL)
            ctrl[i*8 +: 8] <= w_data[i*8 +: 8];
          if (w_strb[i] && aw_addr == OFS_CFG)
            cfg[i*8 +: 8] <= w_data[i*8 +: 8];
        end
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk)
  begin
    if (rst)
      lock_sync <= 3'b000;
    else
      lock_sync <= {lock_sync[1:0], link.lock_pin};
  end
  assign stat = {23'h00_0000, lock_sync[2], link.pump_current_code, 2'b00, link.pll_locked_flag, link.cal_done};
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_CTRL: s_axi_rdata <= ctrl;
        OFS_CFG: s_axi_rdata <= cfg;
        OFS_STAT: s_axi_rdata <= stat;
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // ramp steps and recalibration loops are software's job
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      link.cal_start <= 1'b0;
      link.calib_vctrl_code <= 3'h0;
      link.cal_wait <= 2'b00;
      link.cal_dual <= 1'b0;
      link.cal_fast <= 1'b0;
      link.word_select <= 1'b0;
      link.band_choice <= 1'b0;
      link.amplifier_level_reg <= 8'h00;
      link.loop_bandwidth_setting <= BW_RESET;
      link.lock_select <= LOCK_SEL_RESET;
    end
    else
    begin
      link.cal_start <= ctrl[0];
      link.calib_vctrl_code <= ctrl[3:1];
      link.cal_wait <= ctrl[5:4];
      link.cal_dual <= ctrl[6];
      link.cal_fast <= ctrl[7];
      link.word_select <= ctrl[8];
      link.band_choice <= ctrl[9];
      link.amplifier_level_reg <= ctrl[23:16];
      link.loop_bandwidth_setting <= cfg[7:0];
      link.lock_select <= cfg[11:8];
    end
  end
endmodule // pcc_host

// ---- rtl/pcc_link_if.sv ----
// interface: configuration link between host controller and synthesizer device
`timescale 1ns/10ps
interface pcc_link_if;
  logic cal_start;
  logic [2:0] calib_vctrl_code;
  logic [1:0] cal_wait;
  logic cal_dual;
  logic cal_fast;
  logic word_select;
  logic band_choice;
  logic [7:0] loop_bandwidth_setting;
  logic [3:0] lock_select;
  logic [7:0] amplifier_level_reg;
  logic cal_done;
  logic pll_locked_flag;
  logic [3:0] pump_current_code;
  logic lock_pin;
  modport dev (input cal_start, calib_vctrl_code, cal_wait, cal_dual, cal_fast, word_select, band_choice,
    loop_bandwidth_setting, lock_select, amplifier_level_reg,
    output cal_done, pll_locked_flag, pump_current_code, lock_pin);
  modport host (output cal_start, calib_vctrl_code, cal_wait, cal_dual, cal_fast, word_select, band_choice,
    loop_bandwidth_setting, lock_select, amplifier_level_reg,
    input cal_done, pll_locked_flag, pump_current_code, lock_pin);
endinterface

// ---- rtl/pcc_pkg.sv ----
// package: constants shared by the synthesizer calibration controller ends
package pcc_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  // fast-routine times in microseconds, wait codes 00..11
  localparam int unsigned CAL_US_0 = 1000;
  localparam int unsigned CAL_US_1 = 1500;
  localparam int unsigned CAL_US_2 = 2900;
  localparam int unsigned CAL_US_3 = 3900;
  localparam int unsigned CAL_CYC_0 = CAL_US_0 * (CLK_HZ / 1_000_000);
  localparam int unsigned CAL_CYC_1 = CAL_US_1 * (CLK_HZ / 1_000_000);
  localparam int unsigned CAL_CYC_2 = CAL_US_2 * (CLK_HZ / 1_000_000);
  localparam int unsigned CAL_CYC_3 = CAL_US_3 * (CLK_HZ / 1_000_000);
  localparam int unsigned NORMAL_FACTOR = 2;
  localparam logic [3:0] LOCK_SEL_LOCK = 4'h2;
  localparam logic [3:0] LOCK_SEL_DONE = 4'h5;
  localparam logic [3:0] LOCK_SEL_RESET = 4'h0;
  localparam logic [3:0] PUMP_RESET = 4'h0;
  localparam logic [7:0] BW_RESET = 8'h00;
  // controller register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam int unsigned LOCK_DELAY = 50;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ---- testbench/pcc_monitor.sv ----
// checker: calibration handshake and lock indication on the link
`timescale 1ns/10ps
module pcc_monitor
  import pcc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // link
  input wire logic cal_start,
  input wire logic [3:0] lock_select,
  input wire logic cal_done,
  input wire logic pll_locked_flag,
  input wire logic lock_pin
);
  localparam int MIN_CYC = CAL_CYC_0 - 8;
  localparam int MAX_CYC = CAL_CYC_3 * 4 + 8;
  logic start_q;
  int cyc;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk)
  begin
    start_q <= cal_start;
  end
  // saturates so a long idle spell cannot wrap into range
  always_ff @(posedge mclk)
  begin
    if (rst || (cal_start && !start_q))
      cyc <= 0;
    else if (cyc <= MAX_CYC)
      cyc <= cyc + 1;
  end
  ////////////////////////////////////////////////////////////////
  start_clears_a: assert property (
    $rose(cal_start) |-> ##[1:3] !cal_done) else $error("done not cleared by start");
  done_holds_a: assert property (
    $fell(cal_done) |-> $past(cal_start) || $past(cal_start, 2) || $past(cal_start, 3))
    else $error("done dropped without start");
  cal_min_a: assert property (
    $rose(cal_done) |-> cyc >= MIN_CYC) else $error("calibration too short");
  cal_max_a: assert property (
    $rose(cal_done) |-> cyc <= MAX_CYC) else $error("calibration too long");
  lock_delay_a: assert property (
    $rose(pll_locked_flag) |-> cal_done && $past(cal_done, 40)) else $error("lock too early");
  lock_clears_a: assert property (
    $fell(cal_done) |-> ##[0:3] !pll_locked_flag) else $error("lock kept in calibration");
  done_pin_a: assert property (
    lock_select == LOCK_SEL_DONE && $stable(lock_select) && $stable(cal_done) |-> lock_pin == cal_done)
    else $error("pin does not show done");
  lock_pin_a: assert property (
    lock_select == LOCK_SEL_LOCK && $stable(lock_select) && $stable(pll_locked_flag)
    |-> lock_pin == pll_locked_flag) else $error("pin does not show lock");
endmodule // pcc_monitor

// ---- testbench/tb_pll_calibration_control.sv ----
// testbench: both ends joined, calibration runs ordered over AXI4-Lite
`timescale 1ns/10ps
module tb_pll_calibration_control
  import pcc_pkg::*;
;
  logic mclk = 0, rst = 1;
  logic [7:0] awaddr = 0, araddr = 0, bw, applied_bandwidth;
  logic [31:0] wdata = 0, rdata, c, d;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, band_divider, r;
  logic [2:0] vctrl_nominal;
  int mismatches = 0, n_checks = 0;
  logic [3:0] pa = 4'h0, pb = 4'h0;
  pcc_link_if link ();
  pcc_host i_pcc_host (.mclk(mclk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link));
  pcc_device i_pcc_device (.mclk(mclk), .rst(rst), .link(link), .band_divider(band_divider),
    .applied_bandwidth(applied_bandwidth), .vctrl_nominal(vctrl_nominal));
  pcc_monitor i_pcc_monitor (.mclk(mclk), .rst(rst), .cal_start(link.cal_start),
    .lock_select(link.lock_select), .cal_done(link.cal_done),
    .pll_locked_flag(link.pll_locked_flag), .lock_pin(link.lock_pin));
  ////////////////////////////////////////////////////////////////
  task automatic ck(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x)
    begin
      $display("[ERR] %0t got %h exp %h", $time, g, x);
      mismatches++;
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // aw and w go out together; each is dropped on its own handshake
  // handshakes are judged at the falling edge, where the ready levels have settled for the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    logic aw_go, w_go, b_go;
    @(posedge mclk);
    awaddr <= a;
    wdata <= x;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(negedge mclk);
      aw_go = awvalid && awready;
      w_go = wvalid && wready;
      b_go = bvalid;
      if (b_go)
        r = bresp;
      @(posedge mclk);
      if (aw_go)
        awvalid <= 1'b0;
      if (w_go)
        wvalid <= 1'b0;
    end while (!b_go);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    logic ar_go, r_go;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(negedge mclk);
      ar_go = arvalid && arready;
      r_go = rvalid;
      if (r_go)
      begin
        d = rdata;
        r = rresp;
      end
      @(posedge mclk);
      if (ar_go)
        arvalid <= 1'b0;
    end while (!r_go);
    rready <= 1'b0;
  endtask
  function automatic int cal_cycles(input logic [1:0] w, input logic f, input logic dl);
    int base;
    base = (w == 2'b00) ? CAL_CYC_0 : (w == 2'b01) ? CAL_CYC_1 : (w == 2'b10) ? CAL_CYC_2 : CAL_CYC_3;
    return base * (f ? 1 : NORMAL_FACTOR) * (dl ? 2 : 1);
  endfunction
  ////////////////////////////////////////////////////////////////
  // every run waits out its full calibration time, so the wait codes are spread to fit the run budget
  task automatic cal(input logic f, input logic dl, input logic [3:0] ls, input logic [1:0] w);
    time t0;
    int e;
    logic [3:0] v;
    c = $urandom & 32'h00ff_030e;
    c[7] = f;
    c[6] = dl;
    c[5:4] = w;
    bw = 8'($urandom);
    v = 4'(c[3:1]) + 4'(w);
    if (dl || !c[8])
      pa = v;
    if (dl || c[8])
      pb = v;
    wr(OFS_CFG, {20'h0_0000, ls, bw});
    wr(OFS_CTRL, c);
    repeat (2) @(negedge mclk);
    ck(r, RESP_OKAY);
    ck(link.calib_vctrl_code, c[3:1]);
    ck(link.word_select, c[8]);
    ck(band_divider, c[9] ? 2'b00 : 2'b10);
    ck(link.amplifier_level_reg, c[23:16]);
    wr(OFS_CTRL, c | 32'h0000_0001);
    t0 = $time;
    wr(OFS_CTRL, c);
    rd(OFS_STAT);
    ck(d[0], 1'b0);
    e = cal_cycles(w, f, dl);
    for (int k = 0; k < 90000 && link.cal_done !== 1'b1; k++)
      @(negedge mclk);
    ck(($time - t0) / 100 > e - 8 && ($time - t0) / 100 < e + 8, 1'b1);
    repeat (2) @(negedge mclk);
    ck(link.lock_pin, ls == LOCK_SEL_DONE);
    repeat (LOCK_DELAY + 4) @(posedge mclk);
    rd(OFS_STAT);
    ck(d[1:0], 2'b11);
    ck(d[8], ls == LOCK_SEL_DONE || ls == LOCK_SEL_LOCK);
    ck(d[7:4], v);
    ck(link.lock_pin, ls == LOCK_SEL_DONE || ls == LOCK_SEL_LOCK);
    ck(applied_bandwidth, bw);
    ck(vctrl_nominal, c[3:1]);
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  forever #50 mclk = ~mclk;
  // about 94,000 cycles of calibration waits plus bus traffic
  initial
  begin
    #9_800_000;
    mismatches++;
    results;
  end
  initial
  begin
    void'($urandom(76746));
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    rd(OFS_CFG);
    ck(d, 32'h0000_0000);
    rd(OFS_STAT);
    ck(d, 32'h0000_0000);
    wr(8'h0c, 32'h0000_00ff);
    ck(r, RESP_SLVERR);
    rd(8'h0c);
    ck({r, d[29:0]}, {RESP_SLVERR, 30'h0000_0000});
    cal(1'b1, 1'b0, LOCK_SEL_DONE, 2'b01);
    cal(1'b1, 1'b1, LOCK_SEL_LOCK, 2'b00);
    cal(1'b0, 1'b0, LOCK_SEL_DONE, 2'b00);
    cal(1'b1, 1'b0, LOCK_SEL_RESET, 2'b11);
    wr(OFS_CTRL, 32'h0000_0000);
    rd(OFS_STAT);
    ck(d[7:4], pa);
    wr(OFS_CTRL, 32'h0000_0100);
    rd(OFS_STAT);
    ck(d[7:4], pb);
    for (int p = 0; p < 32; p++)
    begin
      wr(OFS_CTRL, {8'h00, 8'(p < 16 ? p : p + 64), 16'h0000});
      @(negedge mclk);
      ck(link.amplifier_level_reg, 8'(p < 16 ? p : p + 64));
    end
    results;
  end
endmodule // tb_pll_calibration_control
